//--- design/pwm_steer_pkg.sv
// shared constants and types for the pwm duty and output steering block
package pwm_steer_pkg;
   // register byte offsets on the plain register port
   localparam logic [3:0] OFS_CONTROL   = 4'h0; // capture_pwm_control
   localparam logic [3:0] OFS_DUTY_HIGH = 4'h1; // duty_high_reg
   localparam logic [3:0] OFS_SHADOW    = 4'h2; // duty_shadow_reg
   localparam logic [3:0] OFS_PERIOD    = 4'h3; // period_reg
   localparam logic [3:0] OFS_TIMER_CTL = 4'h4; // prescale select and timer run
   localparam logic [3:0] OFS_TIMER     = 4'h5; // period_timer, read only
   localparam logic [3:0] OFS_DEADBAND  = 4'h6; // deadband delay in clocks
   localparam logic [3:0] OFS_DIRECTION = 4'h7; // port_direction_bits
   localparam logic [3:0] OFS_LATCH     = 4'h8; // port_data_latch
   localparam logic [3:0] OFS_PINS      = 4'h9; // live pin levels, read only
   localparam logic [3:0] OFS_RESOL     = 4'ha; // usable duty resolution, read only

   // control, port and timer control register field positions
   localparam int CFG_HI        = 7;  // output_config_bits msb
   localparam int CFG_LO        = 6;  // output_config_bits lsb
   localparam int DUTY_LO_HI    = 5;  // duty low bits msb
   localparam int DUTY_LO_LO    = 4;  // duty low bits lsb
   localparam int MODE_HI       = 3;  // unit mode msb
   localparam int PIN_A_BIT     = 3;  // port bit shared with output a
   localparam int PIN_B_BIT     = 5;  // port bit shared with output b
   localparam int TMR_ON_BIT    = 2;  // timer run bit in timer control

   // mode code that puts the unit in pwm
   localparam logic [3:0] PWM_MODE_CODE = 4'hc;

   // values after reset
   localparam logic [7:0] RST_CONTROL   = 8'h00;
   localparam logic [7:0] RST_DUTY      = 8'h00;
   localparam logic [7:0] RST_PERIOD    = 8'hff;
   localparam logic [7:0] RST_TIMER_CTL = 8'h00;
   localparam logic [7:0] RST_DEADBAND  = 8'h00;
   localparam logic [7:0] RST_DIRECTION = 8'hff; // all pins inputs
   localparam logic [7:0] RST_LATCH     = 8'h00;

   // widths and caps
   localparam int DUTY_W   = 10; // full duty width
   localparam int SPAN_W   = 15; // bits of the widest period span in clocks
   localparam logic [3:0] MAX_RESOL = 4'ha;

   // output pin configurations
   typedef enum logic [1:0] {
      CFG_SINGLE   = 2'b00,
      CFG_HALF     = 2'b01,
      CFG_FULL_FWD = 2'b10,
      CFG_FULL_REV = 2'b11
   } output_config_t;

   // prescale select codes, 2'b11 behaves like 16
   localparam logic [1:0] PRE_1  = 2'b00;
   localparam logic [1:0] PRE_4  = 2'b01;
endpackage

//--- design/deadband_delay.sv
// rising-edge delay stage that opens a dead time before a switch turns on
`timescale 1ns/1ps
module deadband_delay #(
   parameter int DEAD_W = 7
) (
   input  wire logic              core_clk_i,
   input  wire logic              sys_rst_i,
   input  wire logic              ce_i,
   input  wire logic              level_i,   // raw drive request
   input  wire logic [DEAD_W-1:0] delay_i,   // dead time in clocks
   output logic                   out_o      // delayed drive, falls at once
);
   logic [DEAD_W-1:0] count_reg; // clocks spent high so far

   // elaboration check on the counter width
   if (DEAD_W < 1 || DEAD_W > 8) begin : g_bad_width
      $error("deadband width must be 1 to 8");
   end

   // falling edges pass at once so the partner switch is never late to open
   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         count_reg <= '0;
         out_o     <= 1'b0;
      end else if (ce_i) begin
         if (!level_i) begin // request gone: release now
            count_reg <= '0;
            out_o     <= 1'b0;
         end else if (count_reg == delay_i) begin // dead time elapsed
            out_o     <= 1'b1;
         end else begin
            count_reg <= count_reg + 1'b1;
         end
      end
   end

   // output never high while the request is low one cycle before
   a_dead_no_early: assert property (
      @(posedge core_clk_i) disable iff (sys_rst_i)
      (ce_i && !level_i) |=> !out_o)
      else $error("deadband output rose without request");
endmodule

//--- design/pwm_duty_and_output_steering.sv
// pwm duty generator with double-buffered duty and bridge output steering
// How it works
// - duty is high byte plus control bits 5:4
// - high time is duty times clock times prescale
// - new duty latched only at period match
// - shadow register ignores writes in pwm mode
// - shadow byte plus hidden two-bit latch
// - output clears when shadow equals extended timer
// - duty beyond period keeps output high
// - config field picks one of four modes
// - half bridge: b is complement of a
// - programmable deadband between complementary edges
// - resolution limited by log2 of clock ratio
//
// The implementer's own choices: the strobed register port and the register addresses.
`timescale 1ns/1ps
module pwm_duty_and_output_steering
   import pwm_steer_pkg::*;
#(
   parameter int DEAD_W = 7
) (
   input  wire logic       core_clk_i,
   input  wire logic       sys_rst_i,
   input  wire logic       ce_i,
   input  wire logic [3:0] addr_i,
   input  wire logic [7:0] wdata_i,
   input  wire logic       wr_i,
   input  wire logic       rd_i,
   output logic      [7:0] rdata_o,
   input  wire logic       pin_a_i,
   output logic            pin_a_out_o,
   output logic            pin_a_oe_o,
   input  wire logic       pin_b_i,
   output logic            pin_b_out_o,
   output logic            pin_b_oe_o,
   output logic            pwm_out_c_o,
   output logic            pwm_out_d_o
);
   import pwm_steer_pkg::*;

   // software registers
   logic [7:0]        capture_pwm_control; // config, duty low bits, mode
   logic [7:0]        duty_high_reg;       // upper eight duty bits
   logic [7:0]        duty_shadow_reg;     // upper eight live duty bits
   logic [1:0]        duty_low_latch_reg;  // hidden lower live duty bits
   logic [7:0]        period_reg;          // period length in timer counts
   logic [7:0]        timer_ctl_reg;       // prescale select and run bit
   logic [7:0]        period_timer;        // running period count
   logic [DEAD_W-1:0] deadband_reg;        // dead time in clocks
   logic [7:0]        port_direction_bits; // 1 = pin is an input
   logic [7:0]        port_data_latch;     // port value when not steered

   // timebase and waveform state
   logic [1:0]        q_phase_reg;         // quarter-clock phase
   logic [3:0]        presc_reg;           // prescaler count
   logic              pwm_level_reg;       // raw pwm waveform
   logic [1:0]        steer_mode_reg;      // mode as seen by the pins

   // combinational helpers
   logic              pwm_active;          // unit is in pwm mode
   logic              timer_on;            // timebase runs
   logic              q_wrap;              // last quarter phase
   logic              tick;                // period_timer advances now
   logic              match_tick;          // period complete this cycle
   logic [1:0]        sub_bits;            // two sub-cycle bits
   logic [9:0]        duty_req;            // value software asked for
   logic [9:0]        duty_live;           // double-buffered value
   logic              duty_eq;             // extended timer meets duty
   logic              pwm_wave;            // level with the equal cycle masked off
   logic              dead_a;              // delayed drive for a
   logic              dead_b;              // delayed drive for b
   output_config_t    cfg;                 // decoded output config

   // elaboration check on the deadband width
   if (DEAD_W < 1 || DEAD_W > 8) begin : g_bad_width
      $error("deadband width must be 1 to 8");
   end

   // floor of log2 of the period span in clocks, capped at duty width
   function automatic logic [3:0] resolution_bits(input logic [7:0] per,
                                                  input logic [1:0] sel);
      logic [SPAN_W-1:0] span;
      logic [3:0]        b;
      span = SPAN_W'({per, 2'b00}) + SPAN_W'(4);
      b    = 4'h0;
      if (sel == PRE_4) begin
         span = span << 2;
      end else if (sel != PRE_1) begin
         span = span << 4;
      end
      for (int i = 0; i < SPAN_W; i++) begin
         if (span[i]) begin
            b = 4'(i);
         end
      end
      return (b > MAX_RESOL) ? MAX_RESOL : b;
   endfunction

   // decode of mode and config
   assign pwm_active = (capture_pwm_control[MODE_HI:0] == PWM_MODE_CODE);
   assign timer_on   = timer_ctl_reg[TMR_ON_BIT];
   assign cfg        = output_config_t'(capture_pwm_control[CFG_HI:CFG_LO]);
   assign duty_req   = {duty_high_reg, capture_pwm_control[DUTY_LO_HI:DUTY_LO_LO]};
   assign duty_live  = {duty_shadow_reg, duty_low_latch_reg};

   // timer advances once per four clocks times the prescale factor
   always_comb begin
      q_wrap = timer_on && (q_phase_reg == 2'h3);
      if (timer_ctl_reg[1:0] == PRE_1) begin
         tick     = q_wrap;
         sub_bits = q_phase_reg;
      end else if (timer_ctl_reg[1:0] == PRE_4) begin
         tick     = q_wrap && (presc_reg[1:0] == 2'h3);
         sub_bits = presc_reg[1:0];
      end else begin
         tick     = q_wrap && (presc_reg == 4'hf);
         sub_bits = presc_reg[3:2];
      end
   end

   assign match_tick = tick && (period_timer == period_reg);
   // compare counts clocks times prescale, so fewer span bits means fewer duty steps
   assign duty_eq    = ({period_timer, sub_bits} == duty_live);
   // the level flop clears one clock late, so the equal cycle is masked here
   assign pwm_wave   = pwm_level_reg && !duty_eq;

   // quarter phase and prescaler
   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         q_phase_reg <= 2'h0;
         presc_reg   <= 4'h0;
      end else if (ce_i && timer_on) begin
         q_phase_reg <= q_phase_reg + 2'h1;
         if (q_wrap) begin
            presc_reg <= presc_reg + 4'h1;
         end
      end
   end

   // period timer restarts at the period match
   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         period_timer <= 8'h00;
      end else if (ce_i) begin
         if (match_tick) begin
            period_timer <= 8'h00;
         end else if (tick) begin
            period_timer <= period_timer + 8'h01;
         end
      end
   end

   // software register writes
   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         capture_pwm_control <= RST_CONTROL;
         duty_high_reg       <= RST_DUTY;
         period_reg          <= RST_PERIOD;
         timer_ctl_reg       <= RST_TIMER_CTL;
         deadband_reg        <= DEAD_W'(RST_DEADBAND);
         port_direction_bits <= RST_DIRECTION;
         port_data_latch     <= RST_LATCH;
      end else if (ce_i && wr_i) begin
         // duty request accepted at any moment
         unique case (addr_i)
            OFS_CONTROL:   capture_pwm_control <= wdata_i;
            OFS_DUTY_HIGH: duty_high_reg       <= wdata_i;
            OFS_PERIOD:    period_reg          <= wdata_i;
            OFS_TIMER_CTL: timer_ctl_reg       <= wdata_i;
            OFS_DEADBAND:  deadband_reg        <= wdata_i[DEAD_W-1:0];
            OFS_DIRECTION: port_direction_bits <= wdata_i;
            OFS_LATCH:     port_data_latch     <= wdata_i;
            default: ; // shadow (written below), read-only or unmapped: no write here
         endcase
      end
   end

   // duty shadow: copied only at period match, so a period never sees half an update
   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         duty_shadow_reg    <= RST_DUTY;
         duty_low_latch_reg <= 2'h0;
      end else if (ce_i) begin
         if (pwm_active && match_tick) begin
            duty_shadow_reg    <= duty_req[9:2];
            duty_low_latch_reg <= duty_req[1:0];
         end else if (!pwm_active && wr_i && addr_i == OFS_SHADOW) begin
            duty_shadow_reg    <= wdata_i;
         end
      end
   end

   // raw waveform: set at period start, cleared on duty match
   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         pwm_level_reg <= 1'b0;
      end else if (ce_i) begin
         if (!pwm_active) begin
            pwm_level_reg <= 1'b0;
         end else if (match_tick) begin
            pwm_level_reg <= (duty_req != 10'h000);
         end else if (duty_eq) begin
            // duty past the period never matches, so the level stays high
            pwm_level_reg <= 1'b0;
         end
      end
   end

   // complementary drives with dead time for the half bridge
   deadband_delay #(
      .DEAD_W     (DEAD_W)
   ) u_dead_a (
      .core_clk_i (core_clk_i),
      .sys_rst_i  (sys_rst_i),
      .ce_i       (ce_i),
      .level_i    (pwm_wave),
      .delay_i    (deadband_reg),
      .out_o      (dead_a)
   );

   deadband_delay #(
      .DEAD_W     (DEAD_W)
   ) u_dead_b (
      .core_clk_i (core_clk_i),
      .sys_rst_i  (sys_rst_i),
      .ce_i       (ce_i),
      .level_i    (pwm_active && !pwm_wave),
      .delay_i    (deadband_reg),
      .out_o      (dead_b)
   );

   // pin steering; enables follow direction bits that software owns
   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         pin_a_out_o    <= 1'b0;
         pin_b_out_o    <= 1'b0;
         pin_a_oe_o     <= 1'b0;
         pin_b_oe_o     <= 1'b0;
         pwm_out_c_o    <= 1'b0;
         pwm_out_d_o    <= 1'b0;
         steer_mode_reg <= CFG_SINGLE;
      end else if (ce_i) begin
         // a cleared direction bit turns the pin into a driver
         pin_a_oe_o     <= !port_direction_bits[PIN_A_BIT];
         pin_b_oe_o     <= !port_direction_bits[PIN_B_BIT];
         steer_mode_reg <= pwm_active ? cfg : CFG_SINGLE;
         if (!pwm_active) begin // plain port outputs
            pin_a_out_o <= port_data_latch[PIN_A_BIT];
            pin_b_out_o <= port_data_latch[PIN_B_BIT];
            pwm_out_c_o <= 1'b0;
            pwm_out_d_o <= 1'b0;
         end else begin
            unique case (cfg)
               CFG_SINGLE: begin
                  pin_a_out_o <= pwm_wave;
                  pin_b_out_o <= port_data_latch[PIN_B_BIT];
                  pwm_out_c_o <= 1'b0;
                  pwm_out_d_o <= 1'b0;
               end
               CFG_HALF: begin
                  pin_a_out_o <= dead_a;
                  pin_b_out_o <= dead_b;
                  pwm_out_c_o <= 1'b0;
                  pwm_out_d_o <= 1'b0;
               end
               CFG_FULL_FWD: begin
                  pin_a_out_o <= pwm_wave;
                  pin_b_out_o <= 1'b0;
                  pwm_out_c_o <= 1'b0;
                  pwm_out_d_o <= pwm_wave;
               end
               CFG_FULL_REV: begin
                  pin_a_out_o <= 1'b0;
                  pin_b_out_o <= pwm_wave;
                  pwm_out_c_o <= pwm_wave;
                  pwm_out_d_o <= 1'b0;
               end
            endcase
         end
      end
   end

   // read data stand only in the cycle after the strobe
   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         rdata_o <= 8'h00;
      end else if (ce_i) begin
         rdata_o <= 8'h00;
         if (rd_i) begin
            unique case (addr_i)
               OFS_CONTROL:   rdata_o <= capture_pwm_control;
               OFS_DUTY_HIGH: rdata_o <= duty_high_reg;
               OFS_SHADOW:    rdata_o <= duty_shadow_reg;
               OFS_PERIOD:    rdata_o <= period_reg;
               OFS_TIMER_CTL: rdata_o <= timer_ctl_reg;
               OFS_TIMER:     rdata_o <= period_timer;
               OFS_DEADBAND:  rdata_o <= 8'(deadband_reg);
               OFS_DIRECTION: rdata_o <= port_direction_bits;
               OFS_LATCH:     rdata_o <= port_data_latch;
               OFS_PINS:      rdata_o <= {2'h0, pin_b_i, 1'b0, pin_a_i, 3'h0};
               OFS_RESOL:     rdata_o <= {4'h0, resolution_bits(period_reg,
                                                  timer_ctl_reg[1:0])};
               default:       rdata_o <= 8'h00; // unmapped reads as zero
            endcase
         end
      end
   end

   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (sys_rst_i);

   a_duty_latch_match: assert property (
      (ce_i && pwm_active && match_tick) |=> duty_live == $past(duty_req))
      else $error("duty not latched at period match");

   a_shadow_holds: assert property (
      (ce_i && pwm_active && !match_tick) |=> $stable(duty_live))
      else $error("live duty changed outside period match");

   a_clear_on_equal: assert property (
      (ce_i && pwm_active && duty_eq && !match_tick) |=> !pwm_level_reg)
      else $error("output not cleared on duty match");

   a_set_at_period: assert property (
      (ce_i && pwm_active && match_tick && duty_req != 10'h000) |=> pwm_level_reg)
      else $error("output not set at period start");

   a_zero_duty_low: assert property (
      (ce_i && pwm_active && match_tick && duty_req == 10'h000) |=> !pwm_level_reg)
      else $error("zero duty produced a pulse");

   a_timer_restart: assert property (
      (ce_i && match_tick) |=> period_timer == 8'h00)
      else $error("period timer not restarted");

   a_duty_over_high: assert property (
      (ce_i && pwm_active && pwm_level_reg && !match_tick && period_timer <= period_reg
       && duty_live > {period_reg, 2'h3}) |=> pwm_level_reg)
      else $error("output cleared although duty exceeds period");

   a_half_no_overlap: assert property (
      (steer_mode_reg == CFG_HALF && $past(steer_mode_reg) == CFG_HALF)
      |-> !(pin_a_out_o && pin_b_out_o))
      else $error("half bridge outputs high together");

   a_full_fwd_pair: assert property (
      (steer_mode_reg == CFG_FULL_FWD) |-> (!pin_b_out_o && !pwm_out_c_o
       && pin_a_out_o == pwm_out_d_o))
      else $error("forward bridge drove the idle diagonal");

   a_read_one_cycle: assert property (
      (ce_i && !rd_i) |=> rdata_o == 8'h00)
      else $error("read data outside the answer cycle");
endmodule

//--- testbench/bridge_switch_model.sv
// behavioural bridge power switches on the far side of the steered pwm pins
`timescale 1ns/1ps
module bridge_switch_model (
   input  wire logic       core_clk_i,
   input  wire logic       sys_rst_i,
   input  wire logic       pin_a_out_i,
   input  wire logic       pin_a_oe_i,
   input  wire logic       pin_b_out_i,
   input  wire logic       pin_b_oe_i,
   input  wire logic       pwm_out_c_i,
   input  wire logic       pwm_out_d_i,
   output logic            pin_a_o,      // resolved wire level of pin a
   output logic            pin_b_o,      // resolved wire level of pin b
   output logic      [7:0] overlap_o     // cycles with both switches of a leg on
);
   logic last_a_reg;                     // last resolved level of pin a
   logic last_b_reg;                     // last resolved level of pin b

   // released pins carry no pull, so show the inverse of the last level
   assign pin_a_o = pin_a_oe_i ? pin_a_out_i : ~last_a_reg;
   assign pin_b_o = pin_b_oe_i ? pin_b_out_i : ~last_b_reg;

   // remember the last level seen on each wire
   always_ff @(posedge core_clk_i) begin
      last_a_reg <= pin_a_o;
      last_b_reg <= pin_b_o;
   end

   // count shoot-through: both switches of one leg conducting at once
   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         overlap_o <= 8'h00;
      end else if ((pin_a_o && pin_b_o) || (pwm_out_c_i && pwm_out_d_i)) begin
         overlap_o <= overlap_o + 8'h01;
      end
   end
endmodule

//--- testbench/pwm_duty_and_output_steering_tb_top.sv
// register-driven testbench for the pwm duty and output steering block
`timescale 1ns/1ps
module pwm_duty_and_output_steering_tb_top;
   import pwm_steer_pkg::*;
   logic       core_clk_i = 1'b0;        // 10 mhz core clock
   logic       sys_rst_i  = 1'b1;        // held at start
   logic [3:0] addr_i     = 4'h0;        // register address
   logic [7:0] wdata_i    = 8'h00;       // write data
   logic       wr_i       = 1'b0;        // write strobe
   logic       rd_i       = 1'b0;        // read strobe
   logic [7:0] rdata_o;                  // read data
   logic       pin_a_i, pin_a_out_o, pin_a_oe_o;
   logic       pin_b_i, pin_b_out_o, pin_b_oe_o;
   logic       pwm_out_c_o, pwm_out_d_o;
   logic [7:0] overlap;                  // shoot-through cycles from the model
   logic [7:0] got;                      // last read value
   logic [7:0] ov_base;                  // overlap count once single mode is left
   int         mismatches = 0;
   int         checks     = 0;
   int         ca, cb, cc, cd;           // high counts over one period

   always #50 core_clk_i = ~core_clk_i;

   pwm_duty_and_output_steering pwm_duty_and_output_steering_i (
      .core_clk_i (core_clk_i), .sys_rst_i (sys_rst_i), .ce_i (1'b1),
      .addr_i (addr_i), .wdata_i (wdata_i), .wr_i (wr_i), .rd_i (rd_i),
      .rdata_o (rdata_o), .pin_a_i (pin_a_i), .pin_a_out_o (pin_a_out_o),
      .pin_a_oe_o (pin_a_oe_o), .pin_b_i (pin_b_i), .pin_b_out_o (pin_b_out_o),
      .pin_b_oe_o (pin_b_oe_o), .pwm_out_c_o (pwm_out_c_o), .pwm_out_d_o (pwm_out_d_o));

   bridge_switch_model bridge_switch_model_i (
      .core_clk_i (core_clk_i), .sys_rst_i (sys_rst_i), .pin_a_out_i (pin_a_out_o),
      .pin_a_oe_i (pin_a_oe_o), .pin_b_out_i (pin_b_out_o), .pin_b_oe_i (pin_b_oe_o),
      .pwm_out_c_i (pwm_out_c_o), .pwm_out_d_i (pwm_out_d_o), .pin_a_o (pin_a_i),
      .pin_b_o (pin_b_i), .overlap_o (overlap));

   // one-cycle write strobe beside address and data
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge core_clk_i);
      addr_i  <= a;
      wdata_i <= d;
      wr_i    <= 1'b1;
      @(posedge core_clk_i);
      wr_i    <= 1'b0;
   endtask

   // one-cycle read strobe; data stand only in the following cycle
   task automatic rd(input logic [3:0] a);
      @(posedge core_clk_i);
      addr_i <= a;
      rd_i   <= 1'b1;
      @(posedge core_clk_i);
      rd_i   <= 1'b0;
      @(negedge core_clk_i);
      got = rdata_o;
   endtask

   // byte comparison
   task automatic chk_val(input logic [7:0] g, input logic [7:0] e);
      checks++;
      if (g !== e) begin
         mismatches++;
         $display("CHECK FAILED at %0t: value %h expected %h", $time, g, e);
      end
   endtask

   // cycle count comparison, bench-measured count against a fixed expected count
   task automatic chk_cnt(input int g, input int e);
      checks++;
      if (g != e) begin
         mismatches++;
         $display("CHECK FAILED at %0t: count %0d expected %0d", $time, g, e);
      end
   endtask

   // count high cycles of every pin over n consecutive cycles
   task automatic measure(input int n);
      ca = 0; cb = 0; cc = 0; cd = 0;
      repeat (n) begin
         @(negedge core_clk_i);
         ca += (pin_a_i === 1'b1);
         cb += (pin_b_i === 1'b1);
         cc += (pwm_out_c_o === 1'b1);
         cd += (pwm_out_d_o === 1'b1);
      end
   endtask

   // program a waveform, let two periods pass so the shadow has latched it
   task automatic setup(input logic [1:0] cfg, input logic [7:0] dh, input logic [1:0] lsb,
                        input logic [7:0] tctl, input int plen);
      wr(OFS_PERIOD, 8'h03);
      wr(OFS_TIMER_CTL, tctl);
      wr(OFS_DUTY_HIGH, dh);
      wr(OFS_CONTROL, {cfg, lsb, PWM_MODE_CODE});
      repeat (2 * plen + 8) @(posedge core_clk_i);
   endtask

   // verdict and end of run
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   // watchdog well beyond the expected run of under a thousand cycles
   initial begin
      #3000000;
      mismatches++;
      wrap_up();
   end

   // main sequence
   initial begin
      logic [7:0] rst_exp [11];
      rst_exp = '{RST_CONTROL, RST_DUTY, 8'h00, RST_PERIOD, RST_TIMER_CTL, 8'h00,
                  RST_DEADBAND, RST_DIRECTION, RST_LATCH, 8'h00, 8'h00};
      repeat (4) @(posedge core_clk_i);
      sys_rst_i <= 1'b0;
      // reset values, skipping the live timer, pins and resolution
      for (int i = 0; i < 9; i++) begin
         rd(i[3:0]);
         if (i != 5) chk_val(got, rst_exp[i]);
      end
      rd(4'hb);
      chk_val(got, 8'h00);
      // duty held until a period match; shadow ignores writes in pwm mode
      wr(OFS_DUTY_HIGH, 8'h40);
      wr(OFS_CONTROL, {CFG_SINGLE, 2'b00, PWM_MODE_CODE});
      wr(OFS_SHADOW, 8'h55);
      rd(OFS_DUTY_HIGH);
      chk_val(got, 8'h40);
      rd(OFS_SHADOW);
      chk_val(got, 8'h00);
      // release pins a and b as outputs, latch bit 5 high for single mode b
      wr(OFS_DIRECTION, 8'h00);
      wr(OFS_LATCH, 8'h20);
      // single output, duty 6, prescale 1, period 16 clocks
      setup(CFG_SINGLE, 8'h01, 2'b10, 8'h04, 16);
      rd(OFS_SHADOW);
      chk_val(got, 8'h01);
      measure(16);
      chk_cnt(ca, 6);
      chk_cnt(cb, 16);
      rd(OFS_RESOL);
      chk_val(got, 8'h04);
      wr(OFS_RESOL, 8'h00);
      rd(OFS_RESOL);
      chk_val(got, 8'h04);
      // prescale 4 multiplies both high time and period
      setup(CFG_SINGLE, 8'h01, 2'b10, 8'h05, 64);
      measure(64);
      chk_cnt(ca, 24);
      // duty above period keeps the output high; zero duty never sets it
      setup(CFG_SINGLE, 8'h04, 2'b01, 8'h04, 16);
      measure(16);
      chk_cnt(ca, 16);
      setup(CFG_SINGLE, 8'h00, 2'b00, 8'h04, 16);
      measure(16);
      chk_cnt(ca, 0);
      // half bridge without dead time: b complements a
      setup(CFG_HALF, 8'h01, 2'b10, 8'h04, 16);
      // single mode legally had a and b high together; count from here on
      ov_base = overlap;
      measure(16);
      chk_cnt(ca, 6);
      chk_cnt(cb, 10);
      // dead time of 3 clocks trims each rising edge
      wr(OFS_DEADBAND, 8'h03);
      repeat (40) @(posedge core_clk_i);
      measure(16);
      chk_cnt(ca, 3);
      chk_cnt(cb, 7);
      // full bridge forward drives a and d, reverse b and c
      setup(CFG_FULL_FWD, 8'h01, 2'b10, 8'h04, 16);
      measure(16);
      chk_cnt(ca + cd * 100 + cb * 10000 + cc * 1000000, 606);
      setup(CFG_FULL_REV, 8'h01, 2'b10, 8'h04, 16);
      measure(16);
      chk_cnt(ca + cd * 100 + cb * 10000 + cc * 1000000, 6060000);
      chk_val(overlap, ov_base);
      // outside pwm mode the pins follow the port latch
      wr(OFS_LATCH, 8'h08);
      wr(OFS_CONTROL, 8'h00);
      repeat (4) @(posedge core_clk_i);
      rd(OFS_PINS);
      chk_val(got & 8'h28, 8'h08);
      wrap_up();
   end
endmodule
